// ---- scan_ctrl_consts.svh ----
// Constants for the scan and firing controller: codes, timing and rotor geometry
`ifndef SCAN_CTRL_CONSTS_SVH
`define SCAN_CTRL_CONSTS_SVH

// Clock and timing
`define CLK_MHZ 125
`define FIRE_PERIOD_NS 27778
`define FIRE_CYCLES ((`FIRE_PERIOD_NS * `CLK_MHZ) / 1000)
`define SEC_HZ 1
`define SEC_CYCLES ((`CLK_MHZ * 1000000) / `SEC_HZ)
`define RESTART_CYCLES 16

// Reflectivity mapping codes
`define MAP_LINEAR 2'h0
`define MAP_NONLIN1 2'h1
`define MAP_NONLIN2 2'h2

// Return mode codes as reported in the packet tail
`define RET_LAST 3'h0
`define RET_STRONGEST 3'h1
`define RET_FIRST 3'h2
`define RET_LAST_STRONG 3'h3
`define RET_LAST_FIRST 3'h4
`define RET_FIRST_STRONG 3'h5

// Spin rate field values
`define RPM_SLOW 16'h0258
`define RPM_FAST 16'h04B0

// Rotor geometry in tenths of a degree
`define AZ_FULL 12'hE10
`define AZ_HALF 12'h708

`endif

// ---- scan_ctrl_pkg.sv ----
// Types shared by the scan and firing controller
package scan_ctrl_pkg;
	typedef struct packed {
		logic [1:0] refl_map;
		logic [2:0] ret_mode;
		logic ccw;
		logic fast;
		logic sync_en;
		logic [8:0] sync_deg;
		logic trig_time;
		logic standby;
	} cfg_s;

	typedef enum logic [3:0] {
		PTP_FREE = 4'h1,
		PTP_TRACK = 4'h2,
		PTP_LOCK = 4'h4,
		PTP_FROZEN = 4'h8
	} ptp_e;

	typedef enum logic [1:0] {
		ST_RUN = 2'h1,
		ST_RESTART = 2'h2
	} run_e;
endpackage

// ---- fire_gen.sv ----
// Laser firing pulse generator, angle-based or time-based
`timescale 1ns/1ns
`default_nettype none
`include "scan_ctrl_consts.svh"

module fire_gen
	import scan_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	// Control
	input wire logic en_i,
	input wire logic time_mode_i,
	input wire logic fast_i,
	input wire logic tick_i,
	// Firing
	output logic fire_o
);
	logic [11:0] tmr_q, tmr_d;
	logic half_q, half_d;
	logic fire_d;
	logic [12:0] gap_q;

	always_comb begin
		tmr_d = tmr_q;
		half_d = half_q;
		fire_d = 1'b0;
		if (!en_i) begin
			tmr_d = 12'h000;
			half_d = 1'b0;
		end else if (time_mode_i) begin
			half_d = 1'b0;
			if (tmr_q == 12'(`FIRE_CYCLES - 1)) begin
				tmr_d = 12'h000;
				fire_d = 1'b1;
			end else begin
				tmr_d = tmr_q + 12'h001;
			end
		end else begin
			tmr_d = 12'h000;
			if (tick_i) begin
				// At the fast rate every second 0.1 degree step fires
				half_d = fast_i ? ~half_q : 1'b0;
				fire_d = !fast_i || half_q;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tmr_q <= 12'h000;
			half_q <= 1'b0;
			fire_o <= 1'b0;
		end else begin
			tmr_q <= tmr_d;
			half_q <= half_d;
			fire_o <= fire_d;
		end
	end

	// Cycles since the last firing; parked at all ones outside time mode,
	// since the first firing after enable has no earlier firing to measure from
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			gap_q <= 13'h0000;
		end else if (!time_mode_i || !en_i) begin
			gap_q <= 13'h1FFF;
		end else if (fire_o) begin
			gap_q <= 13'h0000;
		end else if (gap_q != 13'h1FFF) begin
			gap_q <= gap_q + 13'h0001;
		end
	end

	time_period_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		fire_o && time_mode_i && en_i && $past(fire_o) == 1'b0 && $past(time_mode_i) && $past(en_i) && gap_q != 13'h1FFF
		|-> gap_q == 13'(`FIRE_CYCLES - 1))
		else $error("time-based firing period wrong");

	angle_fire_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		en_i && !time_mode_i && !fast_i && tick_i |=> fire_o)
		else $error("angle tick did not fire");

	fire_off_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		!en_i |=> !fire_o)
		else $error("firing while disabled");

	fast_fire_c: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		en_i && !time_mode_i && fast_i && fire_o);
endmodule
`default_nettype wire

// ---- lidar_scan_control.sv ----
// Scan, sync, firing and start-up control of the rotating ranging sensor
`timescale 1ns/1ns
`default_nettype none
`include "scan_ctrl_consts.svh"

// What this block does
// - Linear reflectivity encoding by default
// - Two nonlinear curves refine low reflectivity
// - Six return modes, reported in tail
// - Clockwise by default, counterclockwise if set
// - 600 or 1200 RPM, reported in tail
// - Tracking or locked: second from network time
// - Frozen or free-run: internal 1 Hz edge
// - Angle trigger every 0.1 or 0.2 degree
// - Time trigger every 27.778 microseconds
// - Reset-all restores defaults then restarts
// - Each restart increments start-up count
// - Standby stops motor and laser firing
// - Sync state free, tracking, locked, frozen
module lidar_scan_control
	import scan_ctrl_pkg::*;
#(
	parameter int unsigned SEC_CYCLES = `SEC_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	// Host configuration and commands
	input wire logic cfg_wr_i,
	input var cfg_s cfg_i,
	input wire logic restart_i,
	input wire logic reset_all_i,
	// Network time state inputs
	input wire logic master_sel_i,
	input wire logic master_lost_i,
	input wire logic offset_ok_i,
	input wire logic drift_exceeded_i,
	input wire logic ptp_second_i,
	// Rotor encoder pins
	input wire logic rotor_tick_pin_i,
	input wire logic rotor_index_pin_i,
	// Reflectivity path
	input wire logic refl_vld_i,
	input wire logic [7:0] refl_raw_i,
	output logic refl_vld_o,
	output logic [7:0] refl_o,
	// Motor drive
	output logic motor_en_o,
	output logic motor_dir_o,
	output logic [15:0] motor_rpm_o,
	output logic phase_vld_o,
	output logic [11:0] phase_err_o,
	// Laser firing
	output logic fire_o,
	// Status and packet tail fields
	output logic [2:0] ret_mode_o,
	output logic [15:0] spin_field_o,
	output logic [3:0] ptp_state_o,
	output logic second_o,
	output logic restarting_o,
	output logic [15:0] startup_cnt_o
);
	localparam cfg_s CFG_DEFAULT = '{refl_map: `MAP_LINEAR, ret_mode: `RET_LAST_STRONG, ccw: 1'b0,
		fast: 1'b0, sync_en: 1'b0, sync_deg: 9'h000, trig_time: 1'b0, standby: 1'b0};

	function automatic logic [7:0] refl_map_f(input logic [1:0] mode, input logic [7:0] raw);
		logic [7:0] res;
		res = raw;
		if (mode == `MAP_NONLIN1) begin
			res = (raw < 8'h40) ? {raw[6:0], 1'b0} : 8'(8'h80 + ((raw - 8'h40) >> 1));
		end else if (mode == `MAP_NONLIN2) begin
			res = (raw < 8'h20) ? {raw[5:0], 2'b00} : 8'(8'h80 + ((raw - 8'h20) >> 1));
		end
		return res;
	endfunction

	function automatic logic [15:0] rpm_f(input logic fast);
		return fast ? `RPM_FAST : `RPM_SLOW;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Encoder pin synchronisers and edge detection
	logic [2:0] tick_sync_q, idx_sync_q;
	logic tick_evt, idx_evt;

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tick_sync_q <= 3'h0;
			idx_sync_q <= 3'h0;
		end else begin
			tick_sync_q <= {tick_sync_q[1:0], rotor_tick_pin_i};
			idx_sync_q <= {idx_sync_q[1:0], rotor_index_pin_i};
		end
	end
	assign tick_evt = tick_sync_q[1] && !tick_sync_q[2];
	assign idx_evt = idx_sync_q[1] && !idx_sync_q[2];

	////////////////////////////////////////////////////////////////////////
	// Stored and active configuration, restart sequencing
	cfg_s cfg_q, cfg_d, act_q, act_d;
	run_e run_q, run_d;
	logic [4:0] rst_cnt_q, rst_cnt_d;
	logic [15:0] startup_q, startup_d;
	logic frame_evt, busy;

	assign busy = (run_q == ST_RESTART);
	// A stopped rotor has no frame edges, so while idle the settings apply at once
	assign frame_evt = idx_evt || act_q.standby || busy;

	always_comb begin
		cfg_d = cfg_q;
		act_d = act_q;
		run_d = run_q;
		rst_cnt_d = rst_cnt_q;
		startup_d = startup_q;
		if (reset_all_i) begin
			cfg_d = CFG_DEFAULT;
		end else if (cfg_wr_i) begin
			cfg_d = cfg_i;
		end
		// Standby, sync, direction and reflectivity mapping act at once; frame-bound fields wait
		act_d.standby = cfg_q.standby;
		act_d.sync_en = cfg_q.sync_en;
		act_d.sync_deg = cfg_q.sync_deg;
		act_d.ccw = cfg_q.ccw;
		act_d.refl_map = cfg_q.refl_map;
		if (frame_evt) begin
			act_d = cfg_q;
		end
		case (run_q)
			ST_RUN: begin
				if (restart_i || reset_all_i) begin
					run_d = ST_RESTART;
					rst_cnt_d = 5'h00;
				end
			end
			ST_RESTART: begin
				if (rst_cnt_q == 5'(`RESTART_CYCLES - 1)) begin
					run_d = ST_RUN;
					startup_d = startup_q + 16'h0001;
				end else begin
					rst_cnt_d = rst_cnt_q + 5'h01;
				end
			end
			default: run_d = ST_RUN;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cfg_q <= CFG_DEFAULT;
			act_q <= CFG_DEFAULT;
			run_q <= ST_RUN;
			rst_cnt_q <= 5'h00;
			startup_q <= 16'h0000;
		end else begin
			cfg_q <= cfg_d;
			act_q <= act_d;
			run_q <= run_d;
			rst_cnt_q <= rst_cnt_d;
			startup_q <= startup_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Time sync state and full-second source
	ptp_e ptp_q, ptp_d;
	logic [26:0] sec_cnt_q, sec_cnt_d;
	logic int_wrap, sec_evt, ptp_timed;

	assign int_wrap = (sec_cnt_q == 27'(SEC_CYCLES - 1));
	assign ptp_timed = (ptp_q == PTP_TRACK) || (ptp_q == PTP_LOCK);
	assign sec_evt = ptp_timed ? ptp_second_i : int_wrap;

	always_comb begin
		ptp_d = ptp_q;
		sec_cnt_d = int_wrap ? 27'h0000000 : sec_cnt_q + 27'h0000001;
		case (ptp_q)
			PTP_FREE: begin
				if (master_sel_i && !master_lost_i) begin
					ptp_d = offset_ok_i ? PTP_LOCK : PTP_TRACK;
				end
			end
			PTP_TRACK, PTP_LOCK: begin
				if (master_lost_i) begin
					ptp_d = PTP_FROZEN;
				end else if (!master_sel_i) begin
					ptp_d = PTP_FREE;
				end else begin
					ptp_d = offset_ok_i ? PTP_LOCK : PTP_TRACK;
				end
			end
			PTP_FROZEN: begin
				if (drift_exceeded_i) begin
					ptp_d = PTP_FREE;
				end else if (!master_lost_i && master_sel_i) begin
					ptp_d = PTP_TRACK;
				end
			end
			default: ptp_d = PTP_FREE;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ptp_q <= PTP_FREE;
			sec_cnt_q <= 27'h0000000;
		end else begin
			ptp_q <= ptp_d;
			sec_cnt_q <= sec_cnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Rotor azimuth, phase error and output registers
	logic [11:0] az_q, az_d, phase_d;
	logic phase_vld_d;
	logic [12:0] diff;
	logic [11:0] target;
	logic run_ok;

	assign run_ok = !act_q.standby && !busy;
	assign target = 12'({3'h0, act_q.sync_deg} * 12'h00A);
	assign diff = {1'b0, az_q} - {1'b0, target};

	always_comb begin
		az_d = az_q;
		phase_d = phase_err_o;
		phase_vld_d = 1'b0;
		if (idx_evt) begin
			az_d = 12'h000;
		end else if (tick_evt) begin
			az_d = (az_q == `AZ_FULL - 12'h001) ? 12'h000 : az_q + 12'h001;
		end
		// Error folded into half a turn either way, positive means rotor is ahead
		if (sec_evt && act_q.sync_en && run_ok) begin
			phase_vld_d = 1'b1;
			if ($signed(diff) >= $signed({1'b0, `AZ_HALF})) begin
				phase_d = diff[11:0] - `AZ_FULL;
			end else if ($signed(diff) < -$signed({1'b0, `AZ_HALF})) begin
				phase_d = diff[11:0] + `AZ_FULL;
			end else begin
				phase_d = diff[11:0];
			end
		end else if (!act_q.sync_en) begin
			phase_d = 12'h000;
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			az_q <= 12'h000;
			phase_err_o <= 12'h000;
			phase_vld_o <= 1'b0;
			refl_o <= 8'h00;
			refl_vld_o <= 1'b0;
			motor_en_o <= 1'b0;
			motor_dir_o <= 1'b0;
			motor_rpm_o <= `RPM_SLOW;
			ret_mode_o <= `RET_LAST_STRONG;
			spin_field_o <= `RPM_SLOW;
			ptp_state_o <= PTP_FREE;
			second_o <= 1'b0;
			restarting_o <= 1'b0;
			startup_cnt_o <= 16'h0000;
		end else begin
			az_q <= az_d;
			phase_err_o <= phase_d;
			phase_vld_o <= phase_vld_d;
			refl_o <= refl_map_f(act_q.refl_map, refl_raw_i);
			refl_vld_o <= refl_vld_i;
			motor_en_o <= run_ok;
			motor_dir_o <= act_q.ccw;
			motor_rpm_o <= rpm_f(act_q.fast);
			ret_mode_o <= act_q.ret_mode;
			spin_field_o <= rpm_f(act_q.fast);
			ptp_state_o <= ptp_q;
			second_o <= sec_evt;
			restarting_o <= busy;
			startup_cnt_o <= startup_q;
		end
	end

	fire_gen u_fire (
		.ref_clk_i(ref_clk_i),
		.arst_n_i(arst_n_i),
		.en_i(run_ok),
		.time_mode_i(act_q.trig_time),
		.fast_i(act_q.fast),
		.tick_i(tick_evt),
		.fire_o(fire_o)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks
	refl_linear_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		act_q.refl_map == `MAP_LINEAR |=> refl_o == $past(refl_raw_i))
		else $error("linear reflectivity not passed through");
	refl_nonlin_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		act_q.refl_map == `MAP_NONLIN1 && refl_raw_i < 8'h40 |=> refl_o == {$past(refl_raw_i[6:0]), 1'b0})
		else $error("nonlinear curve low range wrong");
	ret_field_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		##1 ret_mode_o == $past(act_q.ret_mode))
		else $error("return mode field mismatch");
	rotor_dir_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		cfg_q.ccw ##1 1'b1 |=> motor_dir_o)
		else $error("direction not applied");
	spin_field_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		act_q.fast |=> spin_field_o == `RPM_FAST && motor_rpm_o == `RPM_FAST)
		else $error("spin rate field wrong");
	phase_lock_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		sec_evt && act_q.sync_en && run_ok |=> phase_vld_o && second_o)
		else $error("phase sample missed");
	ptp_second_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		ptp_timed && !ptp_second_i |=> !second_o)
		else $error("second not from network time");
	int_second_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		!ptp_timed && sec_evt |-> sec_cnt_q == 27'(SEC_CYCLES - 1))
		else $error("internal second edge misplaced");
	reset_all_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		reset_all_i |=> cfg_q == CFG_DEFAULT && busy)
		else $error("reset-all did not restore defaults");
	startup_inc_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		busy && rst_cnt_q == 5'(`RESTART_CYCLES - 1) |=> startup_q == $past(startup_q) + 16'h0001 ##1 !restarting_o)
		else $error("start-up count not incremented");
	standby_stop_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		act_q.standby |=> !motor_en_o && !fire_o)
		else $error("standby did not stop motor or lasers");
	frozen_free_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		ptp_q == PTP_FROZEN && drift_exceeded_i |=> ptp_q == PTP_FREE)
		else $error("frozen state did not fall to free run");
	frame_apply_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		act_q.trig_time != $past(act_q.trig_time) |-> $past(frame_evt))
		else $error("trigger mode changed inside a frame");

	locked_c: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i) ptp_q == PTP_LOCK ##1 second_o);
	restart_c: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i) $fell(restarting_o));
	phase_c: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i) phase_vld_o && act_q.fast);
endmodule
`default_nettype wire

// ---- rotor_ptp_model.sv ----
// Rotor encoder and network time master model for the controller bench
`timescale 1ns/1ns
`default_nettype none
module rotor_ptp_model (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	// Bench control
	input wire logic spin_i,
	input wire logic ptp_run_i,
	// Pins toward the controller
	output logic rotor_tick_pin_o,
	output logic rotor_index_pin_o,
	output logic ptp_second_o
);
	logic [2:0] ph_q;
	logic [3:0] step_q;
	logic [5:0] sec_q;
	// Phase restarts with each spin so that every window holds a known tick count
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ph_q <= 3'h0;
			step_q <= 4'h0;
			sec_q <= 6'h00;
			ptp_second_o <= 1'b0;
		end else begin
			ph_q <= spin_i ? ph_q + 3'h1 : 3'h0;
			if (!spin_i)
				step_q <= 4'h0;
			else if (ph_q == 3'h7)
				step_q <= (step_q == 4'h9) ? 4'h0 : step_q + 4'h1;
			// One second shared by every unit that hangs on this master
			sec_q <= (!ptp_run_i || sec_q == 6'h27) ? 6'h00 : sec_q + 6'h01;
			ptp_second_o <= ptp_run_i && sec_q == 6'h27;
		end
	end
	////////////////////////////////////////////////////////////////
	// Pins idle low between spins, as a stopped encoder reads
	assign rotor_tick_pin_o = spin_i & ph_q[2];
	assign rotor_index_pin_o = spin_i & ph_q[2] & (step_q == 4'h9);
endmodule
`default_nettype wire

// ---- lidar_scan_control_bench.sv ----
// Self-checking bench for the scan and firing controller
`timescale 1ns/1ns
`default_nettype none
`include "scan_ctrl_consts.svh"
module lidar_scan_control_bench
	import scan_ctrl_pkg::*;
();
	logic clk, rst_n, wr, rs, ra, sel, lost, ok, drift, psec, tk, ix, rv, spin, prun;
	cfg_s cfg, def, c;
	logic [7:0] raw, ro;
	logic rvo, men, mdir, pv, fire, sec, rsting;
	logic [15:0] rpm, spinf, scnt, n;
	logic [11:0] perr;
	logic [2:0] ret;
	logic [3:0] pst;
	int miscompares, compares, fires, ticks, secs, phs, cyc, t0;
	logic [7:0] rw [2] = '{8'h0A, 8'h64};
	logic [7:0] mp [3][2] = '{'{8'h0A, 8'h64}, '{8'h14, 8'h92}, '{8'h28, 8'hA2}};

	lidar_scan_control #(.SEC_CYCLES(50)) DUT (.ref_clk_i(clk), .arst_n_i(rst_n), .cfg_wr_i(wr), .cfg_i(cfg),
		.restart_i(rs), .reset_all_i(ra), .master_sel_i(sel), .master_lost_i(lost), .offset_ok_i(ok),
		.drift_exceeded_i(drift), .ptp_second_i(psec), .rotor_tick_pin_i(tk), .rotor_index_pin_i(ix),
		.refl_vld_i(rv), .refl_raw_i(raw), .refl_vld_o(rvo), .refl_o(ro), .motor_en_o(men), .motor_dir_o(mdir),
		.motor_rpm_o(rpm), .phase_vld_o(pv), .phase_err_o(perr), .fire_o(fire), .ret_mode_o(ret),
		.spin_field_o(spinf), .ptp_state_o(pst), .second_o(sec), .restarting_o(rsting), .startup_cnt_o(scnt));
	rotor_ptp_model partner (.ref_clk_i(clk), .arst_n_i(rst_n), .spin_i(spin), .ptp_run_i(prun),
		.rotor_tick_pin_o(tk), .rotor_index_pin_o(ix), .ptp_second_o(psec));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Timeout sized well above the whole sequence
	always @(posedge clk) begin
		cyc++;
		if (fire === 1'b1) fires++;
		if (sec === 1'b1) secs++;
		if (pv === 1'b1) phs++;
		if (cyc == 60000) begin
			miscompares++;
			report_and_stop();
		end
	end
	always @(posedge tk) ticks++;

	////////////////////////////////////////////////////////////////
	task report_and_stop();
		if (miscompares == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	// All stimulus moves on falling edges
	task wait_n(input int k);
		repeat (k) @(negedge clk);
	endtask
	task wr_cfg(input cfg_s v);
		cfg = v;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
		wait_n(4);
	endtask
	// Long enough for one index edge, where deferred settings land outside standby and restart
	task frame();
		spin = 1'b1;
		wait_n(100);
		spin = 1'b0;
		wait_n(10);
	endtask
	task spin_win();
		fires = 0;
		ticks = 0;
		spin = 1'b1;
		wait_n(160);
		spin = 1'b0;
		wait_n(10);
	endtask
	task count_win(input int k);
		secs = 0;
		phs = 0;
		wait_n(k);
	endtask
	task await_rst(input logic lvl);
		for (int i = 0; i < 50 && rsting !== lvl; i++) @(negedge clk);
		chk("restarting", {15'h0000, lvl}, {15'h0000, rsting});
	endtask
	task await_fire();
		for (int i = 0; i < 4000 && fire !== 1'b1; i++) @(negedge clk);
	endtask

	////////////////////////////////////////////////////////////////
	task t_reset();
		chk("rpm in reset", 16'h0258, rpm);
		chk("ret in reset", 16'h0003, 16'(ret));
		chk("sync state in reset", 16'h0001, 16'(pst));
		rst_n = 1'b1;
		wait_n(2);
		chk("motor run", 16'h0001, 16'(men));
		chk("direction", 16'h0000, 16'(mdir));
	endtask
	task t_refl();
		for (int m = 0; m < 3; m++) begin
			c = def;
			c.refl_map = m[1:0];
			wr_cfg(c);
			for (int j = 0; j < 2; j++) begin
				raw = rw[j];
				rv = 1'b1;
				@(negedge clk);
				chk("refl valid", 16'h0001, 16'(rvo));
				chk("refl value", 16'(mp[m][j]), 16'(ro));
			end
			rv = 1'b0;
			@(negedge clk);
			chk("refl idle", 16'h0000, 16'(rvo));
		end
	endtask
	task t_angle();
		spin_win();
		chk("ticks", 16'h0014, 16'(ticks));
		chk("fires slow", 16'h0014, 16'(fires));
		c = def;
		c.fast = 1'b1;
		wr_cfg(c);
		chk("spin before frame", 16'h0258, spinf);
		frame();
		chk("spin field", `RPM_FAST, spinf);
		chk("motor rpm", `RPM_FAST, rpm);
		spin_win();
		chk("fires fast", 16'h000A, 16'(fires));
	endtask
	task t_time();
		c = def;
		c.trig_time = 1'b1;
		wr_cfg(c);
		frame();
		await_fire();
		t0 = cyc;
		@(negedge clk);
		await_fire();
		chk("fire period", 16'(`FIRE_CYCLES), 16'(cyc - t0));
		wr_cfg(def);
		frame();
	endtask
	task t_standby();
		c = def;
		c.standby = 1'b1;
		c.ccw = 1'b1;
		wr_cfg(c);
		chk("motor stopped", 16'h0000, 16'(men));
		chk("direction ccw", 16'h0001, 16'(mdir));
		spin_win();
		chk("standby fires", 16'h0000, 16'(fires));
		wr_cfg(def);
		chk("motor back", 16'h0001, 16'(men));
		chk("direction cw", 16'h0000, 16'(mdir));
	endtask
	task t_sync();
		c = def;
		c.sync_en = 1'b1;
		c.sync_deg = 9'h05A;
		wr_cfg(c);
		count_win(500);
		chk("free seconds", 16'h000A, 16'(secs));
		chk("phase reports", 16'h000A, 16'(phs));
		// Rotor rests at azimuth 0 after the last index, target 90 degrees
		chk("phase error", 16'h0C7C, 16'(perr));
		prun = 1'b1;
		sel = 1'b1;
		ok = 1'b1;
		wait_n(60);
		chk("locked", 16'h0004, 16'(pst));
		count_win(400);
		chk("ptp seconds", 16'h000A, 16'(secs));
		ok = 1'b0;
		wait_n(4);
		chk("tracking", 16'h0002, 16'(pst));
		count_win(400);
		chk("tracking seconds", 16'h000A, 16'(secs));
		lost = 1'b1;
		wait_n(60);
		chk("frozen", 16'h0008, 16'(pst));
		count_win(500);
		chk("frozen seconds", 16'h000A, 16'(secs));
		drift = 1'b1;
		wait_n(4);
		chk("free again", 16'h0001, 16'(pst));
	endtask
	task t_restart();
		n = scnt;
		rs = 1'b1;
		@(negedge clk);
		rs = 1'b0;
		await_rst(1'b1);
		chk("motor in restart", 16'h0000, 16'(men));
		await_rst(1'b0);
		wait_n(2);
		chk("startup count", n + 16'h0001, scnt);
		c = def;
		c.ccw = 1'b1;
		c.ret_mode = 3'h0;
		wr_cfg(c);
		frame();
		ra = 1'b1;
		@(negedge clk);
		ra = 1'b0;
		await_rst(1'b1);
		// A restart while busy must be dropped
		rs = 1'b1;
		@(negedge clk);
		rs = 1'b0;
		await_rst(1'b0);
		wait_n(40);
		chk("idle after restart", 16'h0000, 16'(rsting));
		chk("startup count twice", n + 16'h0002, scnt);
		chk("ret default", 16'h0003, 16'(ret));
		chk("dir default", 16'h0000, 16'(mdir));
		chk("rpm default", 16'h0258, rpm);
	endtask

	initial begin
		{rst_n, wr, rs, ra, sel, lost, ok, drift, rv, spin, prun} = '0;
		raw = 8'h00;
		def = '0;
		def.ret_mode = 3'h3;
		cfg = def;
		wait_n(3);
		t_reset();
		t_refl();
		t_angle();
		t_time();
		t_standby();
		t_sync();
		for (int m = 0; m < 6; m++) begin
			c = def;
			c.ret_mode = m[2:0];
			wr_cfg(c);
			frame();
			chk("return mode", 16'(m), 16'(ret));
		end
		t_restart();
		report_and_stop();
	end
endmodule
`default_nettype wire
